// ===== flash_crc_memory_scanner_bench.sv
// Self-checking bench for the memory scan unit and its flash model.
`timescale 1ns/100ps
module flash_crc_memory_scanner_bench;
   localparam int AW = 10;
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic [1:0] AVS_ADDRESS = 2'h0;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h00000000;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic STARTUP_SCAN_EN = 1'b0;
   logic [1:0] STARTUP_SCAN_SELECT = 2'h0;
   logic FLASH_REQ;
   logic [AW-1:0] FLASH_ADDR;
   logic [15:0] FLASH_RDATA;
   logic SLEEP = 1'b0;
   logic DBG_BUS_ACCESS = 1'b0;
   logic DBG_INTERNAL_ACCESS = 1'b0;
   logic DBG_STATUS_READ = 1'b0;
   logic DBG_BUSY_WRITE = 1'b0;
   logic DBG_BUSY_WDATA = 1'b0;
   logic [1:0] DBG_STATUS_COPY;
   logic CPU_STALL;
   logic CPU_HOLD_RESET;
   logic NMI_REQ;
   logic [31:0] q [$];
   logic [31:0] d;
   logic DBG_DISCONNECT = 1'b0;
   int bad_count = 0;
   int comparisons = 0;
   int nfetch = 0;
   int gap = 99;
   always #5 CLK_SYS = ~CLK_SYS;
   msu_memory_scan_unit #(.ADDR_W(AW)) msu_memory_scan_unit_inst (
      .CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .STARTUP_SCAN_EN(STARTUP_SCAN_EN), .STARTUP_SCAN_SELECT(STARTUP_SCAN_SELECT),
      .BOOT_END_FUSE(2'h1), .APP_END_FUSE(2'h2), .LAST_FLASH_ADDRESS(10'h3FF),
      .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR), .FLASH_RDATA(FLASH_RDATA),
      .SLEEP(SLEEP), .DBG_BUS_ACCESS(DBG_BUS_ACCESS), .DBG_INTERNAL_ACCESS(DBG_INTERNAL_ACCESS),
      .DBG_STATUS_READ(DBG_STATUS_READ), .DBG_DISCONNECT(DBG_DISCONNECT),
      .DBG_BUSY_WRITE(DBG_BUSY_WRITE),
      .DBG_BUSY_WDATA(DBG_BUSY_WDATA), .DBG_STATUS_COPY(DBG_STATUS_COPY),
      .CPU_STALL(CPU_STALL), .CPU_HOLD_RESET(CPU_HOLD_RESET), .NMI_REQ(NMI_REQ));
   msu_flash_model #(.ADDR_W(AW)) msu_flash_model_inst (
      .CLK_SYS(CLK_SYS), .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR),
      .FLASH_RDATA(FLASH_RDATA));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Reads are judged at the accepting edge, where waitrequest is sampled low.
   always @(posedge CLK_SYS) begin
      if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && q.size() > 0) begin
         cmp(AVS_READDATA, q.pop_front());
      end
      gap <= gap + 1;
      if (FLASH_REQ === 1'b1) begin
         if (nfetch == 0) cmp(FLASH_ADDR, 32'h00000000);
         if (gap < 10) cmp(gap, 32'h00000002);
         gap <= 0;
         nfetch++;
      end
   end
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic place(input int e);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int j = 0; j < e - 1; j++) c = crc_byte(c, msu_flash_model_inst.mem[j]);
      msu_flash_model_inst.mem[e - 1] = c[15:8];
      msu_flash_model_inst.mem[e] = c[7:0];
   endtask
   task automatic rst();
      RST <= 1'b1;
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h000000, v};
      AVS_WRITE <= 1'b1;
      @(posedge CLK_SYS);
      while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
      AVS_WRITE <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic rd(input logic [1:0] a, output logic [31:0] v);
      AVS_ADDRESS <= a;
      AVS_READ <= 1'b1;
      @(posedge CLK_SYS);
      while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
      v = AVS_READDATA;
      AVS_READ <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic chk(input logic [1:0] a, input logic [31:0] e);
      logic [31:0] v;
      q.push_back(e);
      rd(a, v);
   endtask
   task automatic wait_idle();
      logic [31:0] v;
      v = 32'h00000001;
      for (int i = 0; i < 2000 && v[0] !== 1'b0; i++) rd(2'h2, v);
   endtask
   task automatic pulse_dbg(input logic [3:0] m);
      {DBG_BUS_ACCESS, DBG_INTERNAL_ACCESS, DBG_STATUS_READ, DBG_DISCONNECT} <= m;
      @(posedge CLK_SYS);
      {DBG_BUS_ACCESS, DBG_INTERNAL_ACCESS, DBG_STATUS_READ, DBG_DISCONNECT} <= 4'h0;
      repeat (5) @(posedge CLK_SYS);
   endtask
   task automatic run(input logic [1:0] s, input int n, input logic [31:0] e);
      wr(2'h1, {6'h00, s});
      nfetch = 0;
      wr(2'h0, 8'h01);
      @(negedge CLK_SYS);
      cmp(CPU_STALL, 32'h00000000);
      repeat (4) @(negedge CLK_SYS);
      cmp(CPU_STALL, 32'h00000001);
      @(posedge CLK_SYS);
      wait_idle();
      cmp(nfetch, n);
      chk(2'h2, e);
   endtask
   initial begin
      void'($urandom(94));
      for (int i = 0; i < 1024; i++) msu_flash_model_inst.mem[i] = 8'($urandom);
      place(255);
      place(511);
      place(1023);
      rst();
      chk(2'h2, 32'h00000002);
      chk(2'h3, 32'h00000000);
      run(2'h0, 512, 32'h00000002);
      run(2'h1, 256, 32'h00000002);
      run(2'h2, 128, 32'h00000002);
      wr(2'h0, 8'h01);
      wr(2'h1, 8'h00);
      repeat (20) @(posedge CLK_SYS);
      SLEEP <= 1'b1;
      repeat (5) @(posedge CLK_SYS);
      d = nfetch;
      repeat (30) @(posedge CLK_SYS);
      cmp(nfetch, d);
      SLEEP <= 1'b0;
      wait_idle();
      chk(2'h2, 32'h00000002);
      chk(2'h1, 32'h00000002);
      nfetch = 0;
      wr(2'h0, 8'h01);
      SLEEP <= 1'b1;
      repeat (20) @(posedge CLK_SYS);
      cmp(nfetch, 32'h00000000);
      SLEEP <= 1'b0;
      wait_idle();
      for (int k = 0; k < 3; k++) begin
         wr(2'h0, 8'h01);
         repeat (20) @(posedge CLK_SYS);
         pulse_dbg(4'h8);
         d = nfetch;
         chk(2'h2, 32'h00000003);
         cmp(nfetch, d);
         cmp(DBG_STATUS_COPY[0], 32'h00000001);
         pulse_dbg(k == 0 ? 4'h4 : (k == 1 ? 4'h2 : 4'h1));
         wait_idle();
         chk(2'h2, 32'h00000002);
      end
      wr(2'h0, 8'h01);
      repeat (20) @(posedge CLK_SYS);
      DBG_BUSY_WRITE <= 1'b1;
      @(posedge CLK_SYS);
      DBG_BUSY_WRITE <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      d = nfetch;
      repeat (20) @(posedge CLK_SYS);
      cmp(DBG_STATUS_COPY[0], 32'h00000000);
      cmp(nfetch, d);
      nfetch = 0;
      DBG_BUSY_WDATA <= 1'b1;
      DBG_BUSY_WRITE <= 1'b1;
      @(posedge CLK_SYS);
      DBG_BUSY_WRITE <= 1'b0;
      wait_idle();
      cmp(nfetch, 32'd128);
      wr(2'h0, 8'h02);
      wr(2'h0, 8'h80);
      chk(2'h0, 32'h00000002);
      chk(2'h2, 32'h00000000);
      msu_flash_model_inst.mem[10] = ~msu_flash_model_inst.mem[10];
      wr(2'h0, 8'h02);
      run(2'h2, 128, 32'h00000000);
      cmp(NMI_REQ, 32'h00000001);
      wr(2'h0, 8'h00);
      chk(2'h0, 32'h00000003);
      STARTUP_SCAN_EN <= 1'b1;
      STARTUP_SCAN_SELECT <= 2'h2;
      rst();
      repeat (600) @(posedge CLK_SYS);
      cmp(CPU_HOLD_RESET, 32'h00000001);
      chk(2'h2, 32'h00000000);
      msu_flash_model_inst.mem[10] = ~msu_flash_model_inst.mem[10];
      rst();
      for (int i = 0; i < 1000 && CPU_HOLD_RESET !== 1'b0; i++) @(posedge CLK_SYS);
      chk(2'h0, 32'h00000001);
      rd(2'h1, d);
      cmp(d[1:0], 32'h00000002);
      chk(2'h2, 32'h00000002);
      results();
   end
   initial begin
      repeat (30000) @(posedge CLK_SYS);
      bad_count++;
      results();
   end
endmodule // flash_crc_memory_scanner_bench

// ===== msu_flash_model.sv
// Flash word read port model that answers the memory scan unit.
`timescale 1ns/100ps
module msu_flash_model #(
   parameter int ADDR_W = 10
) (
   // Clock
   input wire logic CLK_SYS,
   // Flash word read port
   input wire logic FLASH_REQ,
   input wire logic [ADDR_W-1:0] FLASH_ADDR,
   output logic [15:0] FLASH_RDATA
);
   logic [7:0] mem [2**ADDR_W];
   logic [15:0] last_r = 16'h0000;
   // Outside a request the port shows the inverse of the last word, so a late sample fails.
   always_comb begin
      if (FLASH_REQ) begin
         FLASH_RDATA = {mem[{FLASH_ADDR[ADDR_W-1:1], 1'b1}], mem[{FLASH_ADDR[ADDR_W-1:1], 1'b0}]};
      end else begin
         FLASH_RDATA = ~last_r;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (FLASH_REQ) begin
         last_r <= FLASH_RDATA;
      end
   end
endmodule // msu_flash_model

// ===== msu_memory_scan_unit.sv
// Flash CRC memory scan unit with an Avalon-MM register slave.
`timescale 1ns/100ps
`include "msu_params.svh"
module msu_memory_scan_unit #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Avalon-MM register slave
   input wire logic [1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Fuses and section ends (fuse ends in 256-byte pages, last flash address in bytes)
   input wire logic STARTUP_SCAN_EN,
   input wire logic [1:0] STARTUP_SCAN_SELECT,
   input wire logic [ADDR_W-9:0] BOOT_END_FUSE,
   input wire logic [ADDR_W-9:0] APP_END_FUSE,
   input wire logic [ADDR_W-1:0] LAST_FLASH_ADDRESS,
   // Flash word read port
   output logic FLASH_REQ,
   output logic [ADDR_W-1:0] FLASH_ADDR,
   input wire logic [15:0] FLASH_RDATA,
   // CPU and debugger
   input wire logic SLEEP,
   input wire logic DBG_BUS_ACCESS,
   input wire logic DBG_INTERNAL_ACCESS,
   input wire logic DBG_STATUS_READ,
   input wire logic DBG_DISCONNECT,
   input wire logic DBG_BUSY_WRITE,
   input wire logic DBG_BUSY_WDATA,
   output logic [1:0] DBG_STATUS_COPY,
   output logic CPU_STALL,
   output logic CPU_HOLD_RESET,
   output logic NMI_REQ
);
   import msu_pkg::*;

   msu_state_t state_r;
   logic enable_r, fail_ie_r, pass_r, busy_r, dbg_hold_r, startup_r, startup_done_r;
   logic [1:0] sel_r, mode_r, cnt_r;
   logic [15:0] crc_r, word_r;
   logic byte_idx_r;
   logic [ADDR_W-1:0] addr_r;
   logic [ADDR_W-1:0] last_addr;
   logic wr, rd, reg_blocked, sw_start, sw_reset, dbg_kick, running;
   logic rd_wait_r;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         x = {x[14:0], 1'b0} ^ ((x[15] ^ b[i]) ? `MSU_CRC_POLY : 16'h0000);
      end
      return x;
   endfunction

   // Reads take one wait state so the registered read data stands at the accepting edge.
   // Writes are answered in their own cycle.
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rd_wait_r <= 1'b0;
      end else begin
         rd_wait_r <= AVS_READ && !rd_wait_r;
      end
   end
   assign AVS_WAITREQUEST = AVS_READ && !rd_wait_r;
   assign wr = AVS_WRITE && AVS_BYTEENABLE[0];
   assign rd = AVS_READ && !rd_wait_r;
   assign reg_blocked = busy_r || NMI_REQ;
   assign sw_start = wr && AVS_ADDRESS == `MSU_OFS_SCAN_CONTROL && !NMI_REQ
                     && AVS_WRITEDATA[`MSU_BIT_ENABLE];
   assign sw_reset = wr && AVS_ADDRESS == `MSU_OFS_SCAN_CONTROL
                     && AVS_WRITEDATA[`MSU_BIT_SOFT_RESET] && !(fail_ie_r && busy_r);
   // An internal access, disconnect or status-copy read lets the scan run again; a bus access in the same cycle keeps the hold.
   assign dbg_kick = DBG_INTERNAL_ACCESS || DBG_DISCONNECT || DBG_STATUS_READ;

   // Section end address by selection.
   always_comb begin
      case (sel_r)
         // A section ends on the last byte below its end page, where the checksum sits.
         `MSU_SEL_BOOT: last_addr = {BOOT_END_FUSE, 8'h00} - ADDR_W'(1);
         `MSU_SEL_BOOTAPP: last_addr = {APP_END_FUSE, 8'h00} - ADDR_W'(1);
         default: last_addr = LAST_FLASH_ADDRESS;
      endcase
   end

   // Scan work happens only while awake and not held by the debugger.
   // A hold only pauses the walk; the partial checksum is kept, so the verdict is unchanged.
   assign running = !SLEEP && !dbg_hold_r;

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         dbg_hold_r <= 1'b0;
      end else if (DBG_BUS_ACCESS) begin
         dbg_hold_r <= 1'b1;
      end else if (dbg_kick || (DBG_BUSY_WRITE && !DBG_BUSY_WDATA)) begin
         dbg_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         startup_r <= 1'b0;
         startup_done_r <= 1'b0;
      end else if (!startup_done_r) begin
         startup_done_r <= 1'b1;
         startup_r <= STARTUP_SCAN_EN;
      end else if (state_r == MSU_DONE) begin
         startup_r <= 1'b0;
      end
   end

   // Control registers.
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         enable_r <= 1'b0;
         fail_ie_r <= 1'b0;
         sel_r <= 2'h0;
         mode_r <= 2'h0;
      end else if (!startup_done_r && STARTUP_SCAN_EN) begin
         enable_r <= 1'b1;
         sel_r <= STARTUP_SCAN_SELECT;
      end else if (sw_reset) begin
         enable_r <= 1'b0;
         sel_r <= 2'h0;
         mode_r <= 2'h0;
      end else begin
         if (sw_start) begin
            enable_r <= 1'b1;
         end
         if (wr && AVS_ADDRESS == `MSU_OFS_SCAN_CONTROL && !reg_blocked
             && AVS_WRITEDATA[`MSU_BIT_FAIL_IE]) begin
            fail_ie_r <= 1'b1;
         end
         if (wr && AVS_ADDRESS == `MSU_OFS_MODE_SECTION && !reg_blocked) begin
            sel_r <= AVS_WRITEDATA[`MSU_SEL_LSB +: 2];
            mode_r <= AVS_WRITEDATA[`MSU_MODE_LSB +: 2];
         end
      end
   end

   // Scan sequencer: delay, then alternate fetch and two byte hashes.
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_r <= MSU_IDLE;
         cnt_r <= 2'h0;
         busy_r <= 1'b0;
         crc_r <= `MSU_CRC_PRESET;
         addr_r <= '0;
         word_r <= 16'h0000;
         byte_idx_r <= 1'b0;
         pass_r <= 1'b1;
      end else if (sw_reset) begin
         state_r <= MSU_IDLE;
         busy_r <= 1'b0;
         pass_r <= 1'b0;
      end else if (DBG_BUSY_WRITE && !DBG_BUSY_WDATA) begin
         state_r <= MSU_IDLE;
         busy_r <= 1'b0;
      end else begin
         case (state_r)
            MSU_IDLE: begin
               if (sw_start || (DBG_BUSY_WRITE && DBG_BUSY_WDATA)
                   || (!startup_done_r && STARTUP_SCAN_EN)) begin
                  state_r <= MSU_DELAY;
                  cnt_r <= 2'h1;
                  busy_r <= 1'b1;
               end
            end
            MSU_DELAY: begin
               if (running) begin
                  if (cnt_r == `MSU_START_DELAY - 2'h1) begin
                     state_r <= MSU_FETCH;
                     crc_r <= `MSU_CRC_PRESET;
                     addr_r <= '0;
                     cnt_r <= 2'h0;
                  end else begin
                     cnt_r <= cnt_r + 2'h1;
                  end
               end
            end
            MSU_FETCH: begin
               if (running) begin
                  word_r <= FLASH_RDATA;
                  byte_idx_r <= 1'b0;
                  state_r <= MSU_HASH;
               end
            end
            MSU_HASH: begin
               if (running) begin
                  // Low byte sits at the even address, so it goes first.
                  crc_r <= crc_byte(crc_r, byte_idx_r ? word_r[15:8] : word_r[7:0]);
                  byte_idx_r <= 1'b1;
                  if (byte_idx_r) begin
                     if (addr_r[ADDR_W-1:1] == last_addr[ADDR_W-1:1]) begin
                        state_r <= MSU_DONE;
                     end else begin
                        addr_r <= addr_r + ADDR_W'(2);
                        state_r <= MSU_FETCH;
                     end
                  end
               end
            end
            MSU_DONE: begin
               // Residue over data plus stored checksum is zero without final xor.
               pass_r <= (crc_r == 16'h0000);
               busy_r <= 1'b0;
               state_r <= MSU_IDLE;
            end
            default: state_r <= MSU_IDLE;
         endcase
      end
   end

   // Request latches on the first failure while the fail enable is set, and only reset clears it.
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         NMI_REQ <= 1'b0;
      end else if (state_r == MSU_DONE && crc_r != 16'h0000 && fail_ie_r) begin
         NMI_REQ <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         AVS_READDATA <= 32'h0000_0000;
         DBG_STATUS_COPY <= 2'h0;
      end else begin
         DBG_STATUS_COPY <= {pass_r, busy_r};
         if (rd) begin
            case (AVS_ADDRESS)
               `MSU_OFS_SCAN_CONTROL: AVS_READDATA <= {30'h0, fail_ie_r, enable_r};
               `MSU_OFS_MODE_SECTION: AVS_READDATA <= {26'h0, mode_r, 2'h0, sel_r};
               `MSU_OFS_STATUS: AVS_READDATA <= {30'h0, pass_r || busy_r, busy_r};
               default: AVS_READDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign FLASH_REQ = state_r == MSU_FETCH && running;
   assign FLASH_ADDR = addr_r;
   // Stall covers the scan after the start delay, including debugger holds and sleep.
   assign CPU_STALL = busy_r && state_r != MSU_DELAY;
   assign CPU_HOLD_RESET = !startup_done_r || startup_r || (STARTUP_SCAN_EN && !pass_r);

   property p_preset;
      @(posedge CLK_SYS) disable iff (RST)
      (state_r == MSU_DELAY && running && cnt_r == 2'h2) |=> crc_r == 16'hFFFF;
   endproperty
   a_preset: assert property (p_preset) else $error("crc not preset");
   property p_delay;
      @(posedge CLK_SYS) disable iff (RST)
      ($rose(busy_r) && !SLEEP && !DBG_BUS_ACCESS && !dbg_hold_r) ##1 (!SLEEP && !dbg_hold_r)
      |=> state_r == MSU_FETCH;
   endproperty
   a_delay: assert property (p_delay) else $error("start delay wrong");
   // A fetch is followed by two hash cycles, so the next fetch or the end comes third.
   property p_third;
      @(posedge CLK_SYS) disable iff (RST)
      (FLASH_REQ && !DBG_BUSY_WRITE && !sw_reset)
      ##1 (running && !DBG_BUSY_WRITE && !sw_reset)[*2]
      |=> state_r == MSU_FETCH || state_r == MSU_DONE;
   endproperty
   a_third: assert property (p_third) else $error("fetch spacing wrong");
   property p_bound;
      @(posedge CLK_SYS) disable iff (RST)
      FLASH_REQ |-> FLASH_ADDR < last_addr;
   endproperty
   a_bound: assert property (p_bound) else $error("fetch beyond section end");
   property p_rd_wait;
      @(posedge CLK_SYS) disable iff (RST)
      (AVS_READ && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state not ended");
   property p_fail;
      @(posedge CLK_SYS) disable iff (RST)
      (state_r == MSU_DONE && !sw_reset && crc_r != 16'h0000) |=> !pass_r;
   endproperty
   a_fail: assert property (p_fail) else $error("fail not flagged");
   property p_pass;
      @(posedge CLK_SYS) disable iff (RST)
      (state_r == MSU_DONE && !sw_reset && crc_r == 16'h0000) |=> pass_r && !busy_r;
   endproperty
   a_pass: assert property (p_pass) else $error("pass not flagged");
   property p_ie_sticky;
      @(posedge CLK_SYS) disable iff (RST) fail_ie_r |=> fail_ie_r;
   endproperty
   a_ie_sticky: assert property (p_ie_sticky) else $error("fail enable dropped");
   property p_nmi;
      @(posedge CLK_SYS) disable iff (RST)
      (fail_ie_r && state_r == MSU_DONE && crc_r != 16'h0000) |=> NMI_REQ[*3];
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not held");
   property p_sleep;
      @(posedge CLK_SYS) disable iff (RST)
      (SLEEP && state_r == MSU_HASH && !sw_reset && !DBG_BUSY_WRITE) |=> $stable(crc_r);
   endproperty
   a_sleep: assert property (p_sleep) else $error("scan ran in sleep");
   property p_block;
      @(posedge CLK_SYS) disable iff (RST)
      (busy_r && !sw_reset) |=> $stable(sel_r) && $stable(mode_r);
   endproperty
   a_block: assert property (p_block) else $error("control changed while busy");
   property p_dbg_busy;
      @(posedge CLK_SYS) disable iff (RST)
      (dbg_hold_r && busy_r && !DBG_BUSY_WRITE && !sw_reset) |=> busy_r;
   endproperty
   a_dbg_busy: assert property (p_dbg_busy) else $error("busy dropped on hold");
   c_pass: cover property (@(posedge CLK_SYS) state_r == MSU_DONE && crc_r == 16'h0000);
   c_fail: cover property (@(posedge CLK_SYS) $rose(NMI_REQ));
   c_hold: cover property (@(posedge CLK_SYS) dbg_hold_r && busy_r);
   c_startup: cover property (@(posedge CLK_SYS) startup_r && state_r == MSU_DONE);
   c_sleep_delay: cover property (@(posedge CLK_SYS) SLEEP && state_r == MSU_DELAY);
endmodule // msu_memory_scan_unit

// ===== msu_params.svh
// Register offsets, field positions, reset values and timing counts of the memory scan unit.
`ifndef MSU_PARAMS_SVH
`define MSU_PARAMS_SVH
`define MSU_OFS_SCAN_CONTROL 2'h0
`define MSU_OFS_MODE_SECTION 2'h1
`define MSU_OFS_STATUS 2'h2
`define MSU_OFS_DEBUG_STATUS 2'h3
`define MSU_BIT_ENABLE 0
`define MSU_BIT_FAIL_IE 1
`define MSU_BIT_SOFT_RESET 7
`define MSU_BIT_BUSY 0
`define MSU_BIT_PASS 1
`define MSU_SEL_LSB 0
`define MSU_MODE_LSB 4
`define MSU_STATUS_RESET 8'h02
`define MSU_CRC_PRESET 16'hFFFF
`define MSU_CRC_POLY 16'h1021
`define MSU_START_DELAY 2'h3
`define MSU_FETCH_PERIOD 2'h3
`define MSU_SEL_FLASH 2'h0
`define MSU_SEL_BOOTAPP 2'h1
`define MSU_SEL_BOOT 2'h2
`endif

// ===== msu_pkg.sv
// Types shared by the memory scan unit.
package msu_pkg;
   typedef enum logic [4:0] {
      MSU_IDLE = 5'b00001,
      MSU_DELAY = 5'b00010,
      MSU_FETCH = 5'b00100,
      MSU_HASH = 5'b01000,
      MSU_DONE = 5'b10000
   } msu_state_t;
endpackage
